// ==== logic/aac_cfg.svh ====
// offsets, field positions, reset values and timing counts of the block
`ifndef AAC_CFG_SVH
`define AAC_CFG_SVH

`define AAC_OFS_CTRL_A      8'h00
`define AAC_OFS_INPUT       8'h04
`define AAC_OFS_CTRL_C      8'h08
`define AAC_OFS_AVG         8'h0c
`define AAC_OFS_SAMP_TIME   8'h10
`define AAC_OFS_WIN_LO      8'h14
`define AAC_OFS_WIN_HI      8'h18
`define AAC_OFS_GAIN        8'h1c
`define AAC_OFS_OFFSET      8'h20
`define AAC_OFS_TRIG        8'h24
`define AAC_OFS_RESULT      8'h28
`define AAC_OFS_BUSY        8'h2c
`define AAC_OFS_INT_STS     8'h30
`define AAC_OFS_INT_CLR     8'h34
`define AAC_OFS_INT_EN      8'h38

`define AAC_CA_SOFT_RESET   0
`define AAC_CA_ENABLE       1
`define AAC_CA_RUN_STDBY    6
`define AAC_CA_ON_REQUEST   7

`define AAC_PEND_SOFT_RESET_BIT      0
`define AAC_PEND_ENABLE     1
`define AAC_PEND_INPUT      2
`define AAC_PEND_CTRL_C     3
`define AAC_PEND_AVG        4
`define AAC_PEND_SAMP       5
`define AAC_PEND_WIN_LO     6
`define AAC_PEND_WIN_HI     7
`define AAC_PEND_GAIN       8
`define AAC_PEND_OFFSET     9
`define AAC_PEND_TRIG       10
`define AAC_PEND_W          11

`define AAC_INT_RES_READY   0
`define AAC_INT_WINDOW      1
`define AAC_INT_W           2

`define AAC_RES_ACCUM       2'h1
`define AAC_SEL_MAX         4'ha
`define AAC_SEL_NO_SHIFT    4'h4

`define AAC_GAIN_RST        12'h800
`define AAC_PERIPH_DIV      4

`endif

// ==== logic/aac_pkg.sv ====
// types shared by the accumulate/average control block
package aac_pkg;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } aac_wb_req_type;

    typedef struct packed {
        logic        vld;
        logic [11:0] data;
    } aac_smp_type;

    typedef struct packed {
        logic [4:0]  positive_input_sel;
        logic [4:0]  negative_input_sel;
        logic [1:0]  result_resolution;
        logic [3:0]  sample_count_sel;
        logic [2:0]  division_coeff;
        logic [5:0]  sample_time;
        logic [15:0] window_low_threshold;
        logic [15:0] window_high_threshold;
        logic [11:0] gain_correction;
        logic [11:0] offset_correction;
    } aac_cfg_type;

    typedef enum logic [1:0] {
        AAC_IDLE  = 2'b00,
        AAC_START = 2'b01,
        AAC_WAIT  = 2'b10
    } aac_state_type;

endpackage

// ==== logic/aac_accum.sv ====
// sample accumulator with automatic and user right shift
`timescale 1ns/10ps
`include "aac_cfg.svh"
module aac_accum
    import aac_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_b,
    // control
    input  wire logic        i_clr,
    input  wire aac_cfg_type i_cfg,
    // samples
    input  wire aac_smp_type i_smp,
    // result
    output logic             o_last,
    output logic             o_done,
    output logic [15:0]      o_result
);

    logic [21:0] acc_q;
    logic [10:0] cnt_q;
    logic [3:0]  log2_n;
    logic [3:0]  shift;
    logic [21:0] sum;
    logic [21:0] shifted;

    // reserved codes and any resolution other than accumulate collapse to one sample
    function automatic logic [3:0] count_log2(input aac_cfg_type c);
        if (c.result_resolution != `AAC_RES_ACCUM ||
            c.sample_count_sel > `AAC_SEL_MAX)
            return 4'h0;
        return c.sample_count_sel;
    endfunction

    function automatic logic [3:0] total_shift(input aac_cfg_type c);
        logic [3:0] auto_sh;
        auto_sh = 4'h0;
        if (count_log2(c) == 4'h0)
            return 4'h0;
        if (c.sample_count_sel > `AAC_SEL_NO_SHIFT)
            auto_sh = c.sample_count_sel - `AAC_SEL_NO_SHIFT;
        return auto_sh + {1'b0, c.division_coeff};
    endfunction

    assign log2_n  = count_log2(i_cfg);
    assign shift   = total_shift(i_cfg);
    assign sum     = acc_q + {10'h000, i_smp.data};
    assign shifted = sum >> shift;
    assign o_last  = (cnt_q == 11'((12'h001 << log2_n) - 12'h001));

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            acc_q <= 22'h000000;
            cnt_q <= 11'h000;
        end else if (i_clr) begin
            acc_q <= 22'h000000;
            cnt_q <= 11'h000;
        end else if (i_smp.vld && o_last) begin
            acc_q <= 22'h000000;
            cnt_q <= 11'h000;
        end else if (i_smp.vld) begin
            acc_q <= sum;
            cnt_q <= cnt_q + 11'h001;
        end
    end

    // one result per 2^n raw samples
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_done   <= 1'b0;
            o_result <= 16'h0000;
        end else begin
            o_done <= i_smp.vld && o_last && !i_clr;
            if (i_smp.vld && o_last && !i_clr)
                o_result <= shifted[15:0];
        end
    end

endmodule

// ==== logic/aac_ctrl.sv ====
// register file, write synchronisation and sequencing of the converter
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "aac_cfg.svh"
module aac_ctrl
    import aac_pkg::*;
(
    // clock and reset
    input  wire logic           i_clk_sys,
    input  wire logic           i_rst_b,
    // wishbone slave
    input  wire aac_wb_req_type i_wb,
    output logic                o_wb_ack,
    output logic [31:0]         o_wb_dat,
    // power manager
    input  wire logic           i_standby,
    input  wire logic           i_request,
    // converter
    input  wire aac_smp_type    i_smp,
    output logic                o_conv_start,
    output logic                o_conv_on,
    output aac_cfg_type         o_cfg,
    // interrupt
    output logic                o_irq
);

    localparam aac_cfg_type CFG_RST = '{
        gain_correction: `AAC_GAIN_RST,
        default:         '0
    };

    aac_cfg_type             shadow_q;
    logic                    enable_q;
    logic                    run_stdby_q;
    logic                    on_req_q;
    logic                    enable_p_q;
    logic [`AAC_PEND_W-1:0]  pend_q;
    logic [`AAC_PEND_W-1:0]  pend_set;
    logic [2:0]              div_q;
    logic                    tick_q;
    logic                    soft_reset_bit_do;
    logic                    trig_go;
    logic                    wr;
    logic                    rd;
    logic [31:0]             wval;
    logic [31:0]             rval;
    logic [15:0]             result_q;
    logic [`AAC_INT_W-1:0]   int_sts_q;
    logic [`AAC_INT_W-1:0]   int_en_q;
    logic [`AAC_INT_W-1:0]   int_set;
    logic [`AAC_INT_W-1:0]   int_clr;
    logic                    running;
    logic                    acc_last;
    logic                    acc_done;
    logic [15:0]             acc_result;
    aac_state_type           state_q;

    // byte-lane merge of a write onto the current register view
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] dat,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b])
                r[b*8 +: 8] = dat[b*8 +: 8];
        end
        return r;
    endfunction

    function automatic logic [31:0] reg_view(input logic [7:0] adr);
        logic [31:0] r;
        r = 32'h00000000;
        unique case (adr)
            `AAC_OFS_CTRL_A: begin
                r[`AAC_CA_SOFT_RESET] = pend_q[`AAC_PEND_SOFT_RESET_BIT];
                r[`AAC_CA_ENABLE]     = enable_q;
                r[`AAC_CA_RUN_STDBY]  = run_stdby_q;
                r[`AAC_CA_ON_REQUEST] = on_req_q;
            end
            `AAC_OFS_INPUT: begin
                r[4:0]  = shadow_q.positive_input_sel;
                r[12:8] = shadow_q.negative_input_sel;
            end
            `AAC_OFS_CTRL_C:    r[5:4]  = shadow_q.result_resolution;
            `AAC_OFS_AVG: begin
                r[3:0] = shadow_q.sample_count_sel;
                r[6:4] = shadow_q.division_coeff;
            end
            `AAC_OFS_SAMP_TIME: r[5:0]  = shadow_q.sample_time;
            `AAC_OFS_WIN_LO:    r[15:0] = shadow_q.window_low_threshold;
            `AAC_OFS_WIN_HI:    r[15:0] = shadow_q.window_high_threshold;
            `AAC_OFS_GAIN:      r[11:0] = shadow_q.gain_correction;
            `AAC_OFS_OFFSET:    r[11:0] = shadow_q.offset_correction;
            `AAC_OFS_RESULT:    r[15:0] = result_q;
            `AAC_OFS_BUSY:      r[`AAC_PEND_W-1:0] = pend_q;
            `AAC_OFS_INT_STS:   r[`AAC_INT_W-1:0]  = int_sts_q;
            `AAC_OFS_INT_EN:    r[`AAC_INT_W-1:0]  = int_en_q;
            default:            r = 32'h00000000;
        endcase
        return r;
    endfunction

    assign wr       = i_wb.cyc && i_wb.stb && i_wb.we && !o_wb_ack;
    assign rd       = i_wb.cyc && i_wb.stb && !i_wb.we && !o_wb_ack;
    // the view reads state inside a function; always_comb tracks it
    always_comb rval = reg_view(i_wb.adr);
    assign wval     = lane_merge(rval, i_wb.dat, i_wb.sel);
    assign soft_reset_bit_do = tick_q && pend_q[`AAC_PEND_SOFT_RESET_BIT];
    assign trig_go  = tick_q && pend_q[`AAC_PEND_TRIG] && !soft_reset_bit_do;
    assign int_clr  = (wr && i_wb.adr == `AAC_OFS_INT_CLR) ?
                      wval[`AAC_INT_W-1:0] : '0;

    // which write-synchronised registers this bus write touches
    always_comb begin
        pend_set = '0;
        if (wr) begin
            unique case (i_wb.adr)
                `AAC_OFS_CTRL_A: begin
                    pend_set[`AAC_PEND_SOFT_RESET_BIT]  =
                        wval[`AAC_CA_SOFT_RESET];
                    pend_set[`AAC_PEND_ENABLE] =
                        !wval[`AAC_CA_SOFT_RESET];
                end
                `AAC_OFS_INPUT:     pend_set[`AAC_PEND_INPUT]  = 1'b1;
                `AAC_OFS_CTRL_C:    pend_set[`AAC_PEND_CTRL_C] = 1'b1;
                `AAC_OFS_AVG:       pend_set[`AAC_PEND_AVG]    = 1'b1;
                `AAC_OFS_SAMP_TIME: pend_set[`AAC_PEND_SAMP]   = 1'b1;
                `AAC_OFS_WIN_LO:    pend_set[`AAC_PEND_WIN_LO] = 1'b1;
                `AAC_OFS_WIN_HI:    pend_set[`AAC_PEND_WIN_HI] = 1'b1;
                `AAC_OFS_GAIN:      pend_set[`AAC_PEND_GAIN]   = 1'b1;
                `AAC_OFS_OFFSET:    pend_set[`AAC_PEND_OFFSET] = 1'b1;
                `AAC_OFS_TRIG:      pend_set[`AAC_PEND_TRIG]   = wval[0];
                default:            pend_set = '0;
            endcase
        end
    end

    // wishbone answer one cycle after the request
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h00000000;
        end else begin
            o_wb_ack <= wr || rd;
            o_wb_dat <= rd ? rval : 32'h00000000;
        end
    end

    // peripheral-domain rate as an enable pulse
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_q  <= 3'h0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (div_q == 3'(`AAC_PERIPH_DIV - 1));
            if (div_q == 3'(`AAC_PERIPH_DIV - 1))
                div_q <= 3'h0;
            else
                div_q <= div_q + 3'h1;
        end
    end

    // a new write in the tick cycle keeps its bit pending
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b)
            pend_q <= '0;
        else if (soft_reset_bit_do)
            pend_q <= pend_set & ~(`AAC_PEND_W'(1) << `AAC_PEND_SOFT_RESET_BIT);
        else if (tick_q)
            pend_q <= pend_set;
        else
            pend_q <= pend_q | pend_set;
    end

    // values written read back at once; soft reset discards the rest
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            shadow_q    <= CFG_RST;
            enable_q    <= 1'b0;
            run_stdby_q <= 1'b0;
            on_req_q    <= 1'b0;
        end else if (soft_reset_bit_do) begin
            shadow_q    <= CFG_RST;
            enable_q    <= 1'b0;
            run_stdby_q <= 1'b0;
            on_req_q    <= 1'b0;
        end else if (wr) begin
            unique case (i_wb.adr)
                `AAC_OFS_CTRL_A: begin
                    if (!wval[`AAC_CA_SOFT_RESET]) begin
                        enable_q    <= wval[`AAC_CA_ENABLE];
                        run_stdby_q <= wval[`AAC_CA_RUN_STDBY];
                        on_req_q    <= wval[`AAC_CA_ON_REQUEST];
                    end
                end
                `AAC_OFS_INPUT: begin
                    shadow_q.positive_input_sel <= wval[4:0];
                    shadow_q.negative_input_sel <= wval[12:8];
                end
                `AAC_OFS_CTRL_C: shadow_q.result_resolution <= wval[5:4];
                `AAC_OFS_AVG: begin
                    shadow_q.sample_count_sel <= wval[3:0];
                    shadow_q.division_coeff   <= wval[6:4];
                end
                `AAC_OFS_SAMP_TIME: shadow_q.sample_time <= wval[5:0];
                `AAC_OFS_WIN_LO:
                    shadow_q.window_low_threshold <= wval[15:0];
                `AAC_OFS_WIN_HI:
                    shadow_q.window_high_threshold <= wval[15:0];
                `AAC_OFS_GAIN:   shadow_q.gain_correction   <= wval[11:0];
                `AAC_OFS_OFFSET: shadow_q.offset_correction <= wval[11:0];
                default: ;
            endcase
        end
    end

    // peripheral copies change only on the tick, from the latest write
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_cfg      <= CFG_RST;
            enable_p_q <= 1'b0;
        end else if (soft_reset_bit_do) begin
            o_cfg      <= CFG_RST;
            enable_p_q <= 1'b0;
        end else if (tick_q) begin
            if (pend_q[`AAC_PEND_ENABLE])
                enable_p_q <= enable_q;
            if (pend_q[`AAC_PEND_INPUT]) begin
                o_cfg.positive_input_sel <= shadow_q.positive_input_sel;
                o_cfg.negative_input_sel <= shadow_q.negative_input_sel;
            end
            if (pend_q[`AAC_PEND_CTRL_C])
                o_cfg.result_resolution <= shadow_q.result_resolution;
            if (pend_q[`AAC_PEND_AVG]) begin
                o_cfg.sample_count_sel <= shadow_q.sample_count_sel;
                o_cfg.division_coeff   <= shadow_q.division_coeff;
            end
            if (pend_q[`AAC_PEND_SAMP])
                o_cfg.sample_time <= shadow_q.sample_time;
            if (pend_q[`AAC_PEND_WIN_LO])
                o_cfg.window_low_threshold <=
                    shadow_q.window_low_threshold;
            if (pend_q[`AAC_PEND_WIN_HI])
                o_cfg.window_high_threshold <=
                    shadow_q.window_high_threshold;
            if (pend_q[`AAC_PEND_GAIN])
                o_cfg.gain_correction <= shadow_q.gain_correction;
            if (pend_q[`AAC_PEND_OFFSET])
                o_cfg.offset_correction <= shadow_q.offset_correction;
        end
    end

    // sleep behaviour; sleep-mode bits are not synchronised
    assign running = enable_p_q
                  && (!i_standby || run_stdby_q)
                  && (!on_req_q || i_request);

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b)
            o_conv_on <= 1'b0;
        else
            o_conv_on <= running && !soft_reset_bit_do;
    end

    // one trigger runs a whole burst of 2^n conversions
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q      <= AAC_IDLE;
            o_conv_start <= 1'b0;
        end else begin
            o_conv_start <= 1'b0;
            if (soft_reset_bit_do || !running) begin
                state_q <= AAC_IDLE;
            end else begin
                unique case (state_q)
                    AAC_IDLE: begin
                        if (trig_go)
                            state_q <= AAC_START;
                    end
                    AAC_START: begin
                        o_conv_start <= 1'b1;
                        state_q      <= AAC_WAIT;
                    end
                    AAC_WAIT: begin
                        if (i_smp.vld)
                            state_q <= acc_last ? AAC_IDLE : AAC_START;
                    end
                    default: state_q <= AAC_IDLE;
                endcase
            end
        end
    end

    aac_accum u_accum (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .i_clr     (soft_reset_bit_do || !running || state_q == AAC_IDLE),
        .i_cfg     (o_cfg),
        .i_smp     (i_smp),
        .o_last    (acc_last),
        .o_done    (acc_done),
        .o_result  (acc_result)
    );

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b)
            result_q <= 16'h0000;
        else if (soft_reset_bit_do)
            result_q <= 16'h0000;
        else if (acc_done)
            result_q <= acc_result;
    end

    assign int_set[`AAC_INT_RES_READY] = acc_done;
    assign int_set[`AAC_INT_WINDOW]    = acc_done &&
        (acc_result < o_cfg.window_low_threshold ||
         acc_result > o_cfg.window_high_threshold);

    // set beats clear in the same cycle
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            int_sts_q <= '0;
            int_en_q  <= '0;
            o_irq     <= 1'b0;
        end else if (soft_reset_bit_do) begin
            int_sts_q <= '0;
            int_en_q  <= '0;
            o_irq     <= 1'b0;
        end else begin
            int_sts_q <= (int_sts_q & ~int_clr) | int_set;
            if (wr && i_wb.adr == `AAC_OFS_INT_EN)
                int_en_q <= wval[`AAC_INT_W-1:0];
            o_irq <= |(int_sts_q & int_en_q);
        end
    end

endmodule

// ==== verification/aac_ctrl_sva.sv ====
// concurrent checks on the ports of the accumulate/average control block
`timescale 1ns/10ps
`include "aac_cfg.svh"
module aac_ctrl_chk
    import aac_pkg::*;
(
    // clock and reset
    input  wire logic           i_clk_sys,
    input  wire logic           i_rst_b,
    // register bus
    input  wire aac_wb_req_type i_wb,
    input  wire logic           o_wb_ack,
    input  wire logic [31:0]    o_wb_dat,
    // converter and interrupt
    input  wire logic           o_conv_start,
    input  wire logic           o_conv_on,
    input  wire aac_cfg_type    o_cfg,
    input  wire logic           o_irq
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);

    // settles after reset so pre-reset values never feed $changed
    logic [3:0] up_q;
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b)
            up_q <= 4'h0;
        else if (up_q != 4'hf)
            up_q <= up_q + 4'h1;
    end

    ack_answer_a: assert property ((i_wb.cyc && i_wb.stb && !o_wb_ack)
        |=> o_wb_ack) else $error("no ack one cycle after request");
    ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held longer than one cycle");
    ack_cause_a: assert property (o_wb_ack |-> $past(i_wb.cyc && i_wb.stb))
        else $error("ack without a request");
    dat_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
        else $error("read data nonzero without ack");
    cfg_hold_a: assert property ((up_q == 4'hf && $changed(o_cfg))
        |=> $stable(o_cfg) [*3]) else $error("config moved off tick");
    start_gap_a: assert property (o_conv_start
        |=> !o_conv_start [*2]) else $error("conversion starts too close");
    start_on_a: assert property (o_conv_start
        |-> $past(o_conv_on)) else $error("start while converter off");
    irq_mask_a: assert property ((i_wb.cyc && i_wb.stb && i_wb.we
        && !o_wb_ack && i_wb.adr == `AAC_OFS_INT_EN && i_wb.sel[0]
        && i_wb.dat[1:0] == 2'h0) |-> ##[1:3] !o_irq)
        else $error("irq stays high after masking");

    cover property (o_conv_start);
    cover property ($rose(o_irq));
    cover property (o_wb_ack && i_wb.we);
endmodule

// ==== verification/aac_ctrl_test.sv ====
// self-checking bench for the accumulate/average control block
`timescale 1ns/10ps
`include "aac_cfg.svh"
module aac_ctrl_test
    import aac_pkg::*;
;
    logic           i_clk_sys;
    logic           i_rst_b;
    logic           i_standby;
    logic           i_request;
    aac_wb_req_type i_wb;
    aac_smp_type    i_smp;
    logic           o_wb_ack;
    logic           o_conv_start;
    logic           o_conv_on;
    logic           o_irq;
    logic [31:0]    o_wb_dat;
    aac_cfg_type    o_cfg;
    logic [31:0]    rd;
    int             fails;
    int             checks_done;
    int             starts;
    logic [11:0]    tab [6] = '{12'h100, 12'h141, 12'h152, 12'h1a0,
                                12'h1b1, 12'h040};

    aac_ctrl DUT (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_wb(i_wb),
        .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .i_standby(i_standby),
        .i_request(i_request), .i_smp(i_smp), .o_conv_start(o_conv_start),
        .o_conv_on(o_conv_on), .o_cfg(o_cfg), .o_irq(o_irq));

    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end

    // converter stand-in: answers every start one cycle later
    always @(posedge i_clk_sys) begin
        i_smp.vld  <= o_conv_start;
        i_smp.data <= 12'habc;
        if (o_conv_start)
            starts <= starts + 1;
    end

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wbx(input logic we, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        i_wb <= '{1'b1, 1'b1, we, a, 4'hf, d};
        @(posedge i_clk_sys);
        while (o_wb_ack !== 1'b1 && n < 50) begin
            @(posedge i_clk_sys);
            n++;
        end
        chk("ack", 32'(n < 50), 32'h1);
        rd = o_wb_dat;
        i_wb <= '0;
        @(posedge i_clk_sys);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
        wbx(1'b0, a, 32'h0);
        chk(nm, rd, e);
    endtask

    task automatic sync_wait();
        int n;
        n = 0;
        rd = 32'h1;
        while (rd !== 32'h0 && n < 20) begin
            wbx(1'b0, `AAC_OFS_BUSY, 32'h0);
            n++;
        end
        chk("busy", rd, 32'h0);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #200000;
        fails++;
        summarize();
    end

    initial begin
        int n;
        int sh;
        int e;
        fails = 0;
        checks_done = 0;
        starts = 0;
        i_rst_b = 1'b0;
        i_standby = 1'b0;
        i_request = 1'b0;
        i_wb = '0;
        i_smp = '0;
        repeat (6) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        @(posedge i_clk_sys);
        rdc("gain rst", `AAC_OFS_GAIN, 32'h800);
        rdc("ctrl_a rst", `AAC_OFS_CTRL_A, 32'h0);
        rdc("unmapped", 8'h3c, 32'h0);
        chk("cfg gain", 32'(o_cfg.gain_correction), 32'h800);
        $display("test reset done");
        wbx(1'b1, `AAC_OFS_AVG, 32'h23);
        rdc("avg shadow", `AAC_OFS_AVG, 32'h23);
        wbx(1'b1, `AAC_OFS_WIN_LO, 32'h1);
        wbx(1'b1, `AAC_OFS_WIN_LO, 32'h2);
        sync_wait();
        chk("cfg sel", 32'(o_cfg.sample_count_sel), 32'h3);
        chk("cfg win lo", 32'(o_cfg.window_low_threshold), 32'h2);
        $display("test sync done");
        wbx(1'b1, `AAC_OFS_WIN_HI, 32'hffff);
        wbx(1'b1, `AAC_OFS_INT_EN, 32'h1);
        wbx(1'b1, `AAC_OFS_CTRL_A, 32'h2);
        for (int i = 0; i < 6; i++) begin
            n = (tab[i][9:8] == 2'h1 && tab[i][7:4] <= 4'ha) ?
                1 << tab[i][7:4] : 1;
            sh = (n > 1) ? ((tab[i][7:4] > 4'h4) ? tab[i][7:4] - 4 : 0)
                 + tab[i][2:0] : 0;
            e = ((n * 32'habc) >> sh) & 32'hffff;
            wbx(1'b1, `AAC_OFS_CTRL_C, {26'h0, tab[i][9:8], 4'h0});
            wbx(1'b1, `AAC_OFS_AVG, {25'h0, tab[i][2:0], tab[i][7:4]});
            wbx(1'b1, `AAC_OFS_INT_CLR, 32'h3);
            sync_wait();
            starts <= 0;
            wbx(1'b1, `AAC_OFS_TRIG, 32'h1);
            for (int w = 0; w < 8000 && o_irq !== 1'b1; w++)
                @(posedge i_clk_sys);
            rdc("result", `AAC_OFS_RESULT, 32'(e));
            chk("starts", 32'(starts), 32'(n));
            wbx(1'b0, `AAC_OFS_INT_STS, 32'h0);
            chk("sts ready", 32'(rd[0]), 32'h1);
            chk("sts window", 32'(rd[1]), 32'h0);
        end
        $display("test accumulate done");
        wbx(1'b1, `AAC_OFS_INT_EN, 32'h0);
        repeat (2) @(posedge i_clk_sys);
        chk("irq masked", 32'(o_irq), 32'h0);
        wbx(1'b1, `AAC_OFS_INT_EN, 32'h1);
        repeat (2) @(posedge i_clk_sys);
        chk("irq unmasked", 32'(o_irq), 32'h1);
        wbx(1'b1, `AAC_OFS_INT_CLR, 32'h1);
        repeat (2) @(posedge i_clk_sys);
        chk("irq cleared", 32'(o_irq), 32'h0);
        rdc("int_clr read", `AAC_OFS_INT_CLR, 32'h0);
        $display("test interrupt done");
        for (int k = 0; k < 16; k++) begin
            i_standby <= k[2];
            i_request <= k[3];
            wbx(1'b1, `AAC_OFS_CTRL_A, {24'h0, k[1], k[0], 6'h2});
            repeat (3) @(posedge i_clk_sys);
            chk("conv on", 32'(o_conv_on),
                32'((!k[2] || k[0]) && (!k[1] || k[3])));
        end
        i_standby <= 1'b0;
        wbx(1'b1, `AAC_OFS_CTRL_A, 32'h0);
        sync_wait();
        chk("conv off", 32'(o_conv_on), 32'h0);
        $display("test sleep modes done");
        // temperature read: arbitrary input codes, picked before enable
        wbx(1'b1, `AAC_OFS_INPUT, 32'h1918);
        wbx(1'b1, `AAC_OFS_SAMP_TIME, 32'h2a);
        wbx(1'b1, `AAC_OFS_OFFSET, 32'h5a5);
        wbx(1'b1, `AAC_OFS_WIN_HI, 32'h100);
        sync_wait();
        chk("cfg pos", 32'(o_cfg.positive_input_sel), 32'h18);
        chk("cfg neg", 32'(o_cfg.negative_input_sel), 32'h19);
        chk("cfg samp", 32'(o_cfg.sample_time), 32'h2a);
        chk("cfg offset", 32'(o_cfg.offset_correction), 32'h5a5);
        chk("cfg hi", 32'(o_cfg.window_high_threshold), 32'h100);
        wbx(1'b1, `AAC_OFS_INT_CLR, 32'h3);
        wbx(1'b1, `AAC_OFS_CTRL_A, 32'h2);
        sync_wait();
        wbx(1'b1, `AAC_OFS_TRIG, 32'h1);
        for (int w = 0; w < 200 && o_irq !== 1'b1; w++)
            @(posedge i_clk_sys);
        rdc("temp result", `AAC_OFS_RESULT, 32'habc);
        rdc("sts window", `AAC_OFS_INT_STS, 32'h3);
        wbx(1'b1, `AAC_OFS_CTRL_A, 32'h0);
        sync_wait();
        $display("test temperature done");
        wbx(1'b1, `AAC_OFS_INT_EN, 32'h3);
        wbx(1'b1, `AAC_OFS_GAIN, 32'h123);
        wbx(1'b1, `AAC_OFS_CTRL_A, 32'h3);
        sync_wait();
        rdc("gain soft_reset_bit", `AAC_OFS_GAIN, 32'h800);
        rdc("int_en soft_reset_bit", `AAC_OFS_INT_EN, 32'h0);
        rdc("ctrl_a soft_reset_bit", `AAC_OFS_CTRL_A, 32'h0);
        chk("cfg gain", 32'(o_cfg.gain_correction), 32'h800);
        $display("test soft reset done");
        summarize();
    end
endmodule

bind aac_ctrl aac_ctrl_chk u_chk (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_wb(i_wb), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
    .o_conv_start(o_conv_start), .o_conv_on(o_conv_on), .o_cfg(o_cfg),
    .o_irq(o_irq));
